//--- src/gpp_pkg.sv
// Constants and types for the general purpose I/O port
package gpp_pkg;
  localparam int GPP_PINS = 8;
  localparam logic [11:0] GPP_LATCH_OFS = 12'h000;
  localparam logic [11:0] GPP_DIR_OFS = 12'h004;
  localparam logic [11:0] GPP_OPT_OFS = 12'h008;
  localparam logic [11:0] GPP_SENS_OFS = 12'h00C;
  localparam logic [7:0] GPP_LATCH_RST = 8'h00;
  localparam logic [7:0] GPP_DIR_RST = 8'h00;
  localparam logic [7:0] GPP_OPT_RST = 8'h00;
  localparam int GPP_SENS_W = 2;
  localparam int GPP_SENS_LSB = 0;
  localparam int GPP_SYNC_STAGES = 3;

  typedef enum logic [1:0] {
    GPP_SENS_FALL_LOW = 2'b00,
    GPP_SENS_RISE = 2'b01,
    GPP_SENS_FALL = 2'b10,
    GPP_SENS_BOTH = 2'b11
  } gpp_sens_e;

  localparam gpp_sens_e GPP_SENS_RST = GPP_SENS_FALL_LOW;

  typedef enum logic [2:0] {
    GPP_SEL_LATCH = 3'b000,
    GPP_SEL_DIR = 3'b001,
    GPP_SEL_OPT = 3'b010,
    GPP_SEL_SENS = 3'b011,
    GPP_SEL_NONE = 3'b100
  } gpp_sel_e;
endpackage

//--- src/gpp_port.sv
// General purpose I/O port with APB register slave
`timescale 1ns/1ps
module gpp_port
  import gpp_pkg::*;
#(
  parameter int PINS = GPP_PINS,
  parameter logic [PINS-1:0] PULLUP_CAPABLE = '1,
  parameter logic [PINS-1:0] IRQ_CAPABLE = '1
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pads
  input wire logic [PINS-1:0] pad_in,
  output logic [PINS-1:0] pad_out,
  output logic [PINS-1:0] pad_oe,
  output logic [PINS-1:0] pad_pullup_en,
  // Peripheral alternate functions
  input wire logic [PINS-1:0] alt_sel,
  input wire logic [PINS-1:0] alt_out_en,
  input wire logic [PINS-1:0] alt_out,
  input wire logic [PINS-1:0] alt_open_drain,
  output logic [PINS-1:0] alt_in,
  // Interrupt request to the controller
  input wire logic vector_fetch,
  output logic irq_req
);

  logic [PINS-1:0] latch_reg;
  logic [PINS-1:0] dir_reg;
  logic [PINS-1:0] opt_reg;
  gpp_sens_e sens_reg;
  logic [PINS-1:0] sync1_reg;
  logic [PINS-1:0] sync2_reg;
  logic [PINS-1:0] sync3_reg;
  logic [PINS-1:0] pin_lvl_reg;
  logic [PINS-1:0] pin_prev_reg;
  logic [PINS-1:0] pin_lvl_next;
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;
  logic irq_reg;
  logic [PINS-1:0] pad_out_reg;
  logic [PINS-1:0] pad_oe_reg;
  logic [PINS-1:0] pull_reg;
  logic [PINS-1:0] alt_in_reg;

  logic [PINS-1:0] alt_drv;
  logic [PINS-1:0] irq_pin;
  logic [PINS-1:0] pin_event;
  logic [PINS-1:0] read_view;
  logic [PINS-1:0] pad_out_next;
  logic [PINS-1:0] pad_oe_next;
  logic [PINS-1:0] pull_next;
  logic [PINS-1:0] alt_in_next;
  logic access;
  logic wr_en;
  logic sens_chg;
  gpp_sel_e sel;

  function automatic gpp_sel_e decode(input logic [11:0] a);
    unique case (a)
      GPP_LATCH_OFS: decode = GPP_SEL_LATCH;
      GPP_DIR_OFS: decode = GPP_SEL_DIR;
      GPP_OPT_OFS: decode = GPP_SEL_OPT;
      GPP_SENS_OFS: decode = GPP_SEL_SENS;
      default: decode = GPP_SEL_NONE;
    endcase
  endfunction

  // Bus handshake: one wait state, so outputs stay registered
  assign access = psel & penable & pready_reg;
  assign wr_en = access & pwrite;
  assign sel = decode(paddr);
  assign sens_chg = wr_en & (sel == GPP_SEL_SENS) &
    (pwdata[GPP_SENS_LSB +: GPP_SENS_W] != sens_reg);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pready_reg <= 1'b0;
    end else begin
      pready_reg <= psel & penable & ~pready_reg;
    end
  end

  // Register writes
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      latch_reg <= GPP_LATCH_RST;
      dir_reg <= GPP_DIR_RST;
      opt_reg <= GPP_OPT_RST;
      sens_reg <= GPP_SENS_RST;
    end else if (wr_en) begin
      unique case (sel)
        GPP_SEL_LATCH: latch_reg <= pwdata[PINS-1:0];
        GPP_SEL_DIR: dir_reg <= pwdata[PINS-1:0];
        GPP_SEL_OPT: opt_reg <= pwdata[PINS-1:0];
        GPP_SEL_SENS:
          sens_reg <= gpp_sens_e'(pwdata[GPP_SENS_LSB +: GPP_SENS_W]);
        GPP_SEL_NONE: ;
      endcase
    end
  end

  // Pin synchroniser; a change counts once stages two and three agree
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
      pin_lvl_reg <= '0;
      pin_prev_reg <= '0;
    end else begin
      sync1_reg <= pad_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      pin_lvl_reg <= pin_lvl_next;
      pin_prev_reg <= pin_lvl_reg;
    end
  end

  genvar i;
  generate
    for (i = 0; i < PINS; i++) begin : g_pin
      assign pin_lvl_next[i] = (sync2_reg[i] == sync3_reg[i]) ?
        sync3_reg[i] : pin_lvl_reg[i];
    end
  endgenerate

  // Mode decode per pin
  assign alt_drv = alt_sel & alt_out_en;
  assign irq_pin = ~dir_reg & opt_reg & IRQ_CAPABLE & ~alt_sel;

  always_comb begin
    for (int k = 0; k < PINS; k++) begin
      if (alt_drv[k]) begin
        // Peripheral owns the pad, push-pull or open-drain as it asks
        pad_out_next[k] = alt_out[k];
        pad_oe_next[k] = ~alt_open_drain[k] | ~alt_out[k];
        pull_next[k] = 1'b0;
      end else if (dir_reg[k]) begin
        pad_out_next[k] = latch_reg[k];
        pad_oe_next[k] = opt_reg[k] | ~latch_reg[k];
        pull_next[k] = 1'b0;
      end else begin
        pad_out_next[k] = latch_reg[k];
        pad_oe_next[k] = 1'b0;
        pull_next[k] = opt_reg[k] & PULLUP_CAPABLE[k];
      end
      // Output pins hand the latch to the peripheral instead of the pad
      alt_in_next[k] = dir_reg[k] ? latch_reg[k] : pin_lvl_reg[k];
      if (dir_reg[k]) begin
        read_view[k] = latch_reg[k];
      end else if (alt_drv[k]) begin
        read_view[k] = alt_out[k];
      end else begin
        read_view[k] = pin_lvl_reg[k];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pad_out_reg <= '0;
      pad_oe_reg <= '0;
      pull_reg <= '0;
      alt_in_reg <= '0;
    end else begin
      pad_out_reg <= pad_out_next;
      pad_oe_reg <= pad_oe_next;
      pull_reg <= pull_next;
      alt_in_reg <= alt_in_next;
    end
  end

  // Read data and error answer
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      prdata_reg <= '0;
      pslverr_reg <= 1'b0;
    end else if (psel & penable & ~pready_reg) begin
      prdata_reg <= '0;
      pslverr_reg <= (sel == GPP_SEL_NONE);
      if (!pwrite) begin
        unique case (sel)
          GPP_SEL_LATCH: prdata_reg[PINS-1:0] <= read_view;
          GPP_SEL_DIR: prdata_reg[PINS-1:0] <= dir_reg;
          GPP_SEL_OPT: prdata_reg[PINS-1:0] <= opt_reg;
          GPP_SEL_SENS:
            prdata_reg[GPP_SENS_LSB +: GPP_SENS_W] <= sens_reg;
          GPP_SEL_NONE: ;
        endcase
      end
    end
  end

  // Event detection per pin; level mode keeps requesting while low
  always_comb begin
    for (int k = 0; k < PINS; k++) begin
      unique case (sens_reg)
        GPP_SENS_FALL_LOW: pin_event[k] = ~pin_lvl_reg[k];
        GPP_SENS_RISE: pin_event[k] = pin_lvl_reg[k] & ~pin_prev_reg[k];
        GPP_SENS_FALL: pin_event[k] = ~pin_lvl_reg[k] & pin_prev_reg[k];
        GPP_SENS_BOTH: pin_event[k] = pin_lvl_reg[k] ^ pin_prev_reg[k];
      endcase
    end
  end

  // Request latch, no read path; sensitivity change beats a new event
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      irq_reg <= 1'b0;
    end else if (sens_chg) begin
      irq_reg <= 1'b0;
    end else if (|(pin_event & irq_pin)) begin
      irq_reg <= 1'b1;
    end else if (vector_fetch) begin
      irq_reg <= 1'b0;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign pad_out = pad_out_reg;
  assign pad_oe = pad_oe_reg;
  assign pad_pullup_en = pull_reg;
  assign alt_in = alt_in_reg;
  assign irq_req = irq_reg;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  input_read_a: assert property (
    (psel && penable && !pready_reg && !pwrite && sel == GPP_SEL_LATCH)
    |=> (prdata_reg[PINS-1:0] & ~$past(dir_reg) & ~$past(alt_drv)) ==
        ($past(pin_lvl_reg) & ~$past(dir_reg) & ~$past(alt_drv)))
    else $error("input pin read mismatch");

  output_read_a: assert property (
    (psel && penable && !pready_reg && !pwrite && sel == GPP_SEL_LATCH)
    |=> (prdata_reg[PINS-1:0] & $past(dir_reg)) ==
        ($past(latch_reg) & $past(dir_reg)))
    else $error("output pin read mismatch");

  latch_write_a: assert property (
    (wr_en && sel == GPP_SEL_LATCH && dir_reg == '0 && alt_drv == '0)
    |=> latch_reg == $past(pwdata[PINS-1:0]) ##1 pad_oe_reg == '0)
    else $error("latch write disturbed input pins");

  push_pull_a: assert property (
    ##1 ((pad_oe_reg & $past(dir_reg & opt_reg & ~alt_drv)) ==
      $past(dir_reg & opt_reg & ~alt_drv)) &&
    (((pad_out_reg ^ $past(latch_reg)) &
      $past(dir_reg & ~alt_drv)) == '0))
    else $error("push-pull pin not driving latch");

  open_drain_a: assert property (
    ##1 ((pad_oe_reg & $past(dir_reg & ~opt_reg & ~alt_drv)) ==
      ($past(~latch_reg) & $past(dir_reg & ~opt_reg & ~alt_drv))))
    else $error("open-drain enable wrong");

  input_float_a: assert property (
    ##1 ((pad_oe_reg & $past(~dir_reg & ~alt_drv)) == '0))
    else $error("input pin is driven");

  pullup_sel_a: assert property (
    ##1 (pull_reg == $past(~dir_reg & opt_reg & ~alt_drv &
      PULLUP_CAPABLE)))
    else $error("pull-up enable wrong");

  alt_override_a: assert property (
    ##1 (((pad_out_reg ^ $past(alt_out)) & $past(alt_drv)) == '0))
    else $error("alternate output not on pad");

  alt_input_a: assert property (
    ##1 (((alt_in_reg ^ $past(latch_reg)) & $past(dir_reg)) == '0))
    else $error("peripheral not fed from latch");

  fetch_clear_a: assert property (
    (vector_fetch && (pin_event & irq_pin) == '0) |=> !irq_reg)
    else $error("request not cleared on fetch");

  sens_clear_a: assert property (
    sens_chg |=> !irq_reg)
    else $error("request kept after sensitivity change");

  event_set_a: assert property (
    (!sens_chg && (pin_event & irq_pin) != '0) |=> irq_reg)
    else $error("pin event lost");

  // A request never appears without a qualified pin event behind it
  irq_gate_a: assert property (
    $rose(irq_reg) |-> $past((pin_event & irq_pin) != '0))
    else $error("request without pin event");

  level_mode_a: assert property (
    (sens_reg == GPP_SENS_FALL_LOW && !sens_chg &&
      (irq_pin & ~pin_lvl_reg) != '0) |=> irq_reg)
    else $error("low level not requesting");

  alt_read_a: assert property (
    (psel && penable && !pready_reg && !pwrite && sel == GPP_SEL_LATCH)
    |=> ((prdata_reg[PINS-1:0] ^ $past(alt_out)) &
      $past(~dir_reg & alt_drv)) == '0)
    else $error("alternate output not read back");

  alt_oe_a: assert property (
    ##1 (((pad_oe_reg ^ $past(~alt_open_drain | ~alt_out)) &
      $past(alt_drv)) == '0))
    else $error("alternate drive mode wrong");

  alt_feed_a: assert property (
    ##1 (((alt_in_reg ^ $past(pin_lvl_reg)) & $past(~dir_reg)) == '0))
    else $error("peripheral not fed from pin");

  latch_hold_a: assert property (
    !(wr_en && sel == GPP_SEL_LATCH) |=> $stable(latch_reg))
    else $error("latch changed without write");

  // Glitches shorter than two samples must not reach the pin level
  pin_filter_a: assert property (
    ##1 (((pin_lvl_reg ^ $past(pin_lvl_reg)) &
      $past(sync2_reg ^ sync3_reg)) == '0))
    else $error("unfiltered pin change");

  sens_write_a: assert property (
    (wr_en && sel == GPP_SEL_SENS)
    |=> sens_reg == $past(pwdata[GPP_SENS_LSB +: GPP_SENS_W]))
    else $error("sensitivity write lost");

  dir_write_a: assert property (
    (wr_en && sel == GPP_SEL_DIR) |=> dir_reg == $past(pwdata[PINS-1:0]))
    else $error("direction write lost");

  opt_write_a: assert property (
    (wr_en && sel == GPP_SEL_OPT) |=> opt_reg == $past(pwdata[PINS-1:0]))
    else $error("option write lost");

  // Single wait state: the answer is a one-cycle pulse
  ready_pulse_a: assert property (
    pready_reg |=> !pready_reg)
    else $error("ready held too long");

  bad_addr_a: assert property (
    (psel && penable && !pready_reg && sel == GPP_SEL_NONE)
    |=> pslverr_reg && prdata_reg == '0)
    else $error("unmapped access not refused");

endmodule

//--- tb/gpp_board.sv
// Board-side pin model: pads, pull-ups and external drivers
`timescale 1ns/1ps
module gpp_board (
  // Clock
  input wire logic ref_clk,
  // Port pads
  input wire logic [7:0] pad_out,
  input wire logic [7:0] pad_oe,
  input wire logic [7:0] pad_pullup_en,
  output logic [7:0] pad_in,
  // External drivers on the board
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val
);
  logic [7:0] last_reg;
  // Floating pin toggles every cycle so it never passes for a stable level
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pad_oe[i]) begin
        pad_in[i] = pad_out[i];
      end else if (ext_en[i]) begin
        pad_in[i] = ext_val[i];
      end else if (pad_pullup_en[i]) begin
        pad_in[i] = 1'b1;
      end else begin
        pad_in[i] = ~last_reg[i];
      end
    end
  end
  always_ff @(posedge ref_clk) begin
    last_reg <= pad_in;
  end
endmodule

//--- tb/tb.sv
// Self-checking bench for the I/O port
`timescale 1ns/1ps
module tb;
  import gpp_pkg::*;
  logic ref_clk, resetn, psel, penable, pwrite, pready, pslverr;
  logic vector_fetch, irq_req, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] pad_in, pad_out, pad_oe, pu, alt_sel, alt_oe, alt_out;
  logic [7:0] alt_od, alt_in, ext_en, ext_val;
  int err_total, n_compared;

  gpp_port DUT (.ref_clk(ref_clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pullup_en(pu), .alt_sel(alt_sel), .alt_out_en(alt_oe),
    .alt_out(alt_out), .alt_open_drain(alt_od), .alt_in(alt_in),
    .vector_fetch(vector_fetch), .irq_req(irq_req));
  gpp_board board (.ref_clk(ref_clk), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pullup_en(pu), .pad_in(pad_in), .ext_en(ext_en),
    .ext_val(ext_val));

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task wrap_up;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] x);
    n_compared++;
    if (g !== x) begin
      $display("FAIL at %0t got %h exp %h", $time, g, x);
      err_total++;
    end
  endtask

  task cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // Whole-word accesses only; no read-modify-write of the latch
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      err_total++;
      wrap_up;
    end
  endtask

  task wait_irq(input logic v);
    int k;
    k = 0;
    while (irq_req !== v && k < 12) begin
      @(posedge ref_clk);
      k++;
    end
    chk({31'h0, irq_req}, {31'h0, v});
    if (irq_req !== v) wrap_up;
  endtask

  task fetch;
    vector_fetch <= 1'b1;
    @(posedge ref_clk);
    vector_fetch <= 1'b0;
  endtask

  task t_regs;
    apb(1'b0, GPP_DIR_OFS, 32'h0);
    chk(rd, {24'h0, GPP_DIR_RST});
    apb(1'b0, GPP_OPT_OFS, 32'h0);
    chk(rd, {24'h0, GPP_OPT_RST});
    apb(1'b1, GPP_OPT_OFS, 32'h5A);
    apb(1'b0, GPP_OPT_OFS, 32'h0);
    chk(rd, 32'h5A);
    apb(1'b0, 12'h010, 32'h0);
    chk({rd[30:0], er}, 32'h1);
    $display("regs test done");
  endtask

  task t_modes;
    ext_en <= 8'h03;
    ext_val <= 8'h02;
    apb(1'b1, GPP_DIR_OFS, 32'h0);
    apb(1'b1, GPP_LATCH_OFS, 32'hA5);
    cyc(2);
    chk({24'h0, pad_oe}, 32'h0);
    apb(1'b1, GPP_OPT_OFS, 32'hCC);
    apb(1'b1, GPP_DIR_OFS, 32'hF0);
    cyc(6);
    chk({24'h0, pad_oe}, 32'hD0);
    chk({24'h0, pad_out & pad_oe}, 32'h80);
    chk({24'h0, pu}, 32'h0C);
    apb(1'b0, GPP_LATCH_OFS, 32'h0);
    chk(rd, 32'hAE);
    $display("modes test done");
  endtask

  // Alternate pin 0 drives the pad push-pull, then releases it open-drain; peripheral inputs come from pin 1 and from the latch of pins 7:4
  task t_alt;
    ext_en <= 8'h02;
    alt_sel <= 8'h11;
    alt_oe <= 8'h01;
    alt_out <= 8'h01;
    cyc(6);
    apb(1'b0, GPP_LATCH_OFS, 32'h0);
    chk({pad_oe[0], pad_out[0], rd[0], alt_in[1]}, 32'hF);
    chk({28'h0, alt_in[7:4]}, 32'hA);
    alt_od <= 8'h01;
    cyc(2);
    chk({31'h0, pad_oe[0]}, 32'h0);
    alt_sel <= 8'h00;
    alt_oe <= 8'h00;
    alt_od <= 8'h00;
    $display("alternate test done");
  endtask

  task t_irq;
    ext_en <= 8'h07;
    ext_val <= 8'h07;
    apb(1'b1, GPP_DIR_OFS, 32'h0);
    apb(1'b1, GPP_OPT_OFS, 32'h03);
    apb(1'b1, GPP_SENS_OFS, {30'h0, GPP_SENS_FALL});
    cyc(8);
    fetch;
    wait_irq(1'b0);
    ext_val <= 8'h03;
    cyc(8);
    chk({31'h0, irq_req}, 32'h0);
    ext_val <= 8'h01;
    wait_irq(1'b1);
    fetch;
    wait_irq(1'b0);
    ext_val <= 8'h00;
    wait_irq(1'b1);
    apb(1'b1, GPP_SENS_OFS, {30'h0, GPP_SENS_BOTH});
    wait_irq(1'b0);
    ext_val <= 8'h02;
    wait_irq(1'b1);
    fetch;
    wait_irq(1'b0);
    apb(1'b1, GPP_SENS_OFS, {30'h0, GPP_SENS_RISE});
    ext_val <= 8'h00;
    cyc(8);
    chk({31'h0, irq_req}, 32'h0);
    ext_val <= 8'h01;
    wait_irq(1'b1);
    apb(1'b1, GPP_SENS_OFS, {30'h0, GPP_SENS_FALL_LOW});
    fetch;
    cyc(2);
    chk({31'h0, irq_req}, 32'h1);
    ext_val <= 8'h03;
    cyc(6);
    fetch;
    wait_irq(1'b0);
    $display("interrupt test done");
  endtask

  initial begin
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    vector_fetch = 1'b0;
    alt_sel = 8'h00;
    alt_oe = 8'h00;
    alt_out = 8'h00;
    alt_od = 8'h00;
    ext_en = 8'hFF;
    ext_val = 8'h00;
    err_total = 0;
    n_compared = 0;
    cyc(3);
    resetn <= 1'b1;
    t_regs;
    t_modes;
    t_alt;
    t_irq;
    wrap_up;
  end
endmodule
